// >>> hdl/i2csm_defs.svh
`ifndef I2CSM_DEFS_SVH
`define I2CSM_DEFS_SVH

// ************************************************************
// register indices, byte address is four times the index
// ************************************************************
`define I2CSM_IDX_SLAVE_ADDR     10'h001
`define I2CSM_IDX_SLAVE_CTRL     10'h003
`define I2CSM_IDX_STATUS         10'h010
`define I2CSM_IDX_MAP_LAST       10'h0E0
`define I2CSM_IDX_MAP_BASE_LOW   10'h0E1
`define I2CSM_IDX_MAP_BASE_MID   10'h0E2
`define I2CSM_IDX_MAP_BASE_HIGH  10'h0E3

// ************************************************************
// field positions and reset values
// ************************************************************
`define I2CSM_CTRL_AUTOINC_BIT   0
`define I2CSM_CTRL_MASTER_BIT    1
`define I2CSM_CTRL_MAPMODE_BIT   2
`define I2CSM_RST_SLAVE_ADDR     8'h5C
`define I2CSM_RST_SLAVE_CTRL     8'h00
`define I2CSM_RST_MAP_BASE       8'h00
`define I2CSM_RST_TX_BYTE        8'hFF

// ************************************************************
// address space
// ************************************************************
`define I2CSM_DMA_BASE           24'h800000
`define I2CSM_MAP_HALF_BIT       6

`endif

// >>> hdl/i2csm_pkg.sv
package i2csm_pkg;

    // ************************************************************
    // serial engine states
    // ************************************************************
    typedef enum logic [2:0] {
        I2CSM_IDLE,
        I2CSM_ADDR,
        I2CSM_RXD,
        I2CSM_ACK_OUT,
        I2CSM_TXD,
        I2CSM_ACK_IN
    } i2csm_state_t;

endpackage : i2csm_pkg

// >>> hdl/i2csm_sync.sv
// ************************************************************
// two flop synchroniser with edge detect
// ************************************************************
module i2csm_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic din,
    output logic      q,
    output logic      rise,
    output logic      fall
);

    logic meta;
    logic prev;

    // pin idles high, so flops reset high to avoid a false edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= 1'b1;
            q    <= 1'b1;
            prev <= 1'b1;
        end else begin
            meta <= din;
            q    <= meta;
            prev <= q;
        end
    end

    assign rise = q & ~prev;
    assign fall = ~q & prev;

endmodule : i2csm_sync

// >>> hdl/i2csm_top.sv
`include "i2csm_defs.svh"

module i2csm_top #(
    parameter int ADDR_W = 12
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              scl_i,
    output logic                   scl_o,
    output logic                   scl_oe,
    input  wire logic              sda_i,
    output logic                   sda_o,
    output logic                   sda_oe,
    output logic                   mem_req,
    output logic                   mem_we,
    output logic      [23:0]       mem_addr,
    output logic      [7:0]        mem_wdata,
    input  wire logic [7:0]        mem_rdata,
    input  wire logic              mem_ack
);

    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0]                slave_address_reg;
    logic [7:0]                slave_control_reg;
    logic [7:0]                map_last_offset;
    logic [7:0]                map_base_low;
    logic [7:0]                map_base_mid;
    logic [7:0]                map_base_high;
    logic [7:0]                access_addr_high;
    logic [7:0]                access_addr_mid;
    logic [7:0]                access_addr_low;

    logic                      scl_s;
    logic                      scl_rise;
    logic                      scl_fall;
    logic                      sda_s;
    logic                      sda_rise;
    logic                      sda_fall;
    logic                      start_det;
    logic                      stop_det;
    logic                      slave_en;
    logic                      map_mode;
    logic                      auto_inc;

    i2csm_pkg::i2csm_state_t   state;
    logic [7:0]                shift;
    logic [3:0]                bitcnt;
    logic                      rw;
    logic                      rx_done;
    logic                      fetch_go;
    logic [7:0]                tx_byte;
    logic [1:0]                idx;
    logic [5:0]                wptr;
    logic [5:0]                rptr;
    logic [6:0]                last_acc;
    logic                      touched;

    logic [9:0]                reg_idx;
    logic                      apb_take;
    logic                      apb_done;
    logic                      mapped;
    logic [31:0]               rd_val;
    logic [23:0]               dma_addr;
    logic [23:0]               map_base;

    // ************************************************************
    // pin sampling
    // ************************************************************
    // plain oversampling is enough for both rates given the clock ratio
    i2csm_sync u_scl_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (scl_i),
        .q       (scl_s),
        .rise    (scl_rise),
        .fall    (scl_fall)
    );

    i2csm_sync u_sda_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (sda_i),
        .q       (sda_s),
        .rise    (sda_rise),
        .fall    (sda_fall)
    );

    assign start_det = sda_fall & scl_s;
    assign stop_det  = sda_rise & scl_s;
    assign slave_en  = ~slave_control_reg[`I2CSM_CTRL_MASTER_BIT];
    assign map_mode  = slave_control_reg[`I2CSM_CTRL_MAPMODE_BIT];
    assign auto_inc  = slave_control_reg[`I2CSM_CTRL_AUTOINC_BIT];
    assign dma_addr  = `I2CSM_DMA_BASE + {access_addr_high, access_addr_mid, access_addr_low};
    assign map_base  = {map_base_high, map_base_mid, map_base_low};

    // ************************************************************
    // apb slave
    // ************************************************************
    assign reg_idx  = paddr[ADDR_W-1:2];
    assign apb_take = psel & penable & ~pready;
    assign apb_done = psel & penable & pready;

    always_comb begin
        mapped = (paddr[1:0] == 2'h0);
        rd_val = 32'h0;
        case (reg_idx)
            `I2CSM_IDX_SLAVE_ADDR:    rd_val = {24'h0, slave_address_reg};
            `I2CSM_IDX_SLAVE_CTRL:    rd_val = {24'h0, slave_control_reg};
            `I2CSM_IDX_MAP_LAST:      rd_val = {24'h0, map_last_offset};
            `I2CSM_IDX_MAP_BASE_LOW:  rd_val = {24'h0, map_base_low};
            `I2CSM_IDX_MAP_BASE_MID:  rd_val = {24'h0, map_base_mid};
            `I2CSM_IDX_MAP_BASE_HIGH: rd_val = {24'h0, map_base_high};
            `I2CSM_IDX_STATUS:        rd_val = {8'h0, dma_addr[7:0], 8'h0, 4'h0, rw, mem_req,
                                               (state != i2csm_pkg::I2CSM_IDLE), slave_en};
            default:                  mapped = 1'b0;
        endcase
    end

    // one wait state: answer comes in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= apb_take;
            pslverr <= apb_take & ~mapped;
            if (apb_take && !pwrite) begin
                prdata <= mapped ? rd_val : 32'h0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slave_address_reg <= `I2CSM_RST_SLAVE_ADDR;
            slave_control_reg <= `I2CSM_RST_SLAVE_CTRL;
            map_base_low      <= `I2CSM_RST_MAP_BASE;
            map_base_mid      <= `I2CSM_RST_MAP_BASE;
            map_base_high     <= `I2CSM_RST_MAP_BASE;
        end else if (apb_done && pwrite && paddr[1:0] == 2'h0) begin
            case (reg_idx)
                `I2CSM_IDX_SLAVE_ADDR:    slave_address_reg <= pwdata[7:0];
                `I2CSM_IDX_SLAVE_CTRL:    slave_control_reg <= pwdata[7:0];
                `I2CSM_IDX_MAP_BASE_LOW:  map_base_low      <= pwdata[7:0];
                `I2CSM_IDX_MAP_BASE_MID:  map_base_mid      <= pwdata[7:0];
                `I2CSM_IDX_MAP_BASE_HIGH: map_base_high     <= pwdata[7:0];
                default:                  ;
            endcase
        end
    end

    // ************************************************************
    // serial engine
    // ************************************************************
    // no clock stretching, so read data must arrive within one scl high phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state    <= i2csm_pkg::I2CSM_IDLE;
            shift    <= 8'h00;
            bitcnt   <= 4'h0;
            rw       <= 1'b0;
            sda_oe   <= 1'b0;
            rx_done  <= 1'b0;
            fetch_go <= 1'b0;
        end else begin
            rx_done  <= 1'b0;
            fetch_go <= 1'b0;
            if (stop_det || !slave_en) begin
                state  <= i2csm_pkg::I2CSM_IDLE;
                sda_oe <= 1'b0;
            end else if (start_det) begin
                state  <= i2csm_pkg::I2CSM_ADDR;
                bitcnt <= 4'h0;
                sda_oe <= 1'b0;
            end else begin
                case (state)
                    i2csm_pkg::I2CSM_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    i2csm_pkg::I2CSM_ADDR, i2csm_pkg::I2CSM_RXD: begin
                        if (scl_rise && bitcnt != 4'h8) begin
                            shift  <= {shift[6:0], sda_s};
                            bitcnt <= bitcnt + 4'h1;
                        end
                        if (scl_fall && bitcnt == 4'h8) begin
                            if (state == i2csm_pkg::I2CSM_RXD) begin
                                sda_oe  <= 1'b1;
                                rx_done <= 1'b1;
                                state   <= i2csm_pkg::I2CSM_ACK_OUT;
                            end else if (shift[7:1] == slave_address_reg[7:1]) begin
                                sda_oe   <= 1'b1;
                                rw       <= shift[0];
                                fetch_go <= shift[0];
                                state    <= i2csm_pkg::I2CSM_ACK_OUT;
                            end else begin
                                state <= i2csm_pkg::I2CSM_IDLE;
                            end
                        end
                    end
                    i2csm_pkg::I2CSM_ACK_OUT: begin
                        if (scl_fall) begin
                            if (rw) begin
                                sda_oe <= ~tx_byte[7];
                                shift  <= {tx_byte[6:0], 1'b0};
                                bitcnt <= 4'h1;
                                state  <= i2csm_pkg::I2CSM_TXD;
                            end else begin
                                sda_oe <= 1'b0;
                                bitcnt <= 4'h0;
                                state  <= i2csm_pkg::I2CSM_RXD;
                            end
                        end
                    end
                    i2csm_pkg::I2CSM_TXD: begin
                        if (scl_fall) begin
                            if (bitcnt == 4'h8) begin
                                sda_oe <= 1'b0;
                                state  <= i2csm_pkg::I2CSM_ACK_IN;
                            end else begin
                                sda_oe <= ~shift[7];
                                shift  <= {shift[6:0], 1'b0};
                                bitcnt <= bitcnt + 4'h1;
                            end
                        end
                    end
                    i2csm_pkg::I2CSM_ACK_IN: begin
                        if (scl_rise) begin
                            if (sda_s) begin
                                state <= i2csm_pkg::I2CSM_IDLE;
                            end else begin
                                fetch_go <= 1'b1;
                                state    <= i2csm_pkg::I2CSM_ACK_OUT;
                            end
                        end
                    end
                    default: begin
                        state <= i2csm_pkg::I2CSM_IDLE;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // internal access
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_req          <= 1'b0;
            mem_we           <= 1'b0;
            mem_addr         <= 24'h0;
            mem_wdata        <= 8'h00;
            idx              <= 2'h0;
            access_addr_high <= 8'h00;
            access_addr_mid  <= 8'h00;
            access_addr_low  <= 8'h00;
            wptr             <= 6'h00;
            rptr             <= 6'h00;
            last_acc         <= 7'h00;
            touched          <= 1'b0;
        end else begin
            if (mem_req && mem_ack) begin
                mem_req <= 1'b0;
            end
            if (start_det) begin
                idx <= 2'h0;
            end
            if (stop_det) begin
                wptr    <= 6'h00;
                rptr    <= 6'h00;
                touched <= 1'b0;
            end else if (rx_done && map_mode) begin
                mem_req   <= 1'b1;
                mem_we    <= 1'b1;
                mem_addr  <= map_base + {18'h0, wptr};
                mem_wdata <= shift;
                last_acc  <= {1'b0, wptr};
                touched   <= 1'b1;
                wptr      <= wptr + 6'h01;
            end else if (fetch_go && map_mode) begin
                mem_req  <= 1'b1;
                mem_we   <= 1'b0;
                mem_addr <= map_base + {17'h0, 1'b1, rptr};
                last_acc <= {1'b1, rptr};
                touched  <= 1'b1;
                rptr     <= rptr + 6'h01;
            end else if (rx_done && idx != 2'h3) begin
                idx <= idx + 2'h1;
                case (idx)
                    2'h0:    access_addr_high <= shift;
                    2'h1:    access_addr_mid  <= shift;
                    default: access_addr_low  <= shift;
                endcase
            end else if (rx_done || fetch_go) begin
                mem_req   <= 1'b1;
                mem_we    <= rx_done;
                mem_addr  <= dma_addr;
                mem_wdata <= shift;
                if (auto_inc) begin
                    {access_addr_high, access_addr_mid, access_addr_low} <=
                        {access_addr_high, access_addr_mid, access_addr_low} + 24'h1;
                end
            end
        end
    end

    // ************************************************************
    // read data and window status
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_byte         <= `I2CSM_RST_TX_BYTE;
            map_last_offset <= 8'h00;
        end else begin
            if (mem_req && mem_ack && !mem_we) begin
                tx_byte <= mem_rdata;
            end
            // a stop with no window access keeps the old value
            if (stop_det && touched) begin
                map_last_offset <= {1'b0, last_acc};
            end
        end
    end

    // ************************************************************
    // fixed pin drives
    // ************************************************************
    // open drain: only the data enable sda_oe moves, scl_oe stays low and the driven level is always low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sda_o  <= 1'b0;
            scl_o  <= 1'b0;
            scl_oe <= 1'b0;
        end else begin
            sda_o  <= 1'b0;
            scl_o  <= 1'b0;
            scl_oe <= 1'b0;
        end
    end

endmodule : i2csm_top

// >>> verification/i2csm_chk_sva.sv
// ************************************************************
// port checker for the slave port
// ************************************************************
module i2csm_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        scl_i,
    input wire logic        scl_o,
    input wire logic        scl_oe,
    input wire logic        sda_o,
    input wire logic        sda_oe,
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic [23:0] mem_addr,
    input wire logic        mem_ack
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_one_wait_state: assert property (($rose(penable) && psel) |-> !pready ##1 pready)
        else $error("apb answer not after one wait state");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_scl_released: assert property (!scl_oe && !scl_o)
        else $error("serial clock driven");
    a_sda_open_drain: assert property (!sda_o)
        else $error("data line driven high");
    a_sda_low_clock: assert property ($changed(sda_oe) |-> !scl_i)
        else $error("data line moved while clock high");
    a_mem_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
        else $error("memory request dropped or changed");
    a_mem_req_done: assert property (mem_req && mem_ack |=> !mem_req)
        else $error("memory request not closed");
    a_mem_spacing: assert property ($fell(mem_req) |-> !mem_req [*8])
        else $error("memory accesses too close");
endmodule : i2csm_chk

bind i2csm_top i2csm_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o),
    .sda_oe(sda_oe),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_ack(mem_ack));

// >>> verification/i2csm_master_mdl.sv
// ************************************************************
// external bus master, 125 ns bit time
// ************************************************************
module i2csm_master_mdl (
    output logic      scl,
    output logic      sda,
    input  wire logic sda_bus
);
    timeunit 1ns;
    timeprecision 100ps;
    // quarter bit; pclk stays over ten times the bit rate
    localparam realtime Q = 31.25;
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic put(input logic b);
        #Q sda = b;
        #Q scl = 1'b1;
        #(2*Q) scl = 1'b0;
    endtask : put
    task automatic get(output logic b);
        #Q sda = 1'b1;
        #Q scl = 1'b1;
        #Q b = sda_bus;
        #Q scl = 1'b0;
    endtask : get
    task automatic start();
        #Q sda = 1'b1;
        #Q scl = 1'b1;
        #Q sda = 1'b0;
        #Q scl = 1'b0;
    endtask : start
    // clock stays high afterwards, so the bus rests idle
    task automatic stop();
        #Q sda = 1'b0;
        #Q scl = 1'b1;
        #Q sda = 1'b1;
        #Q;
    endtask : stop
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) put(d[i]);
        get(a);
        ack = !a;
    endtask : wr_byte
    task automatic rd_byte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) get(d[i]);
        put(last);
    endtask : rd_byte
endmodule : i2csm_master_mdl

// >>> verification/i2csm_tb.sv
module i2csm_tb;
    timeunit 1ns;
    timeprecision 100ps;
    // ************************************************************
    // signals, memory responder and helpers
    // ************************************************************
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, mem_req, mem_we, mdl_scl, mdl_sda;
    logic [23:0] mem_addr;
    logic [7:0]  mem_wdata;
    logic [7:0]  mem_rdata = 8'hE7;
    logic        mem_ack = 1'b0;
    logic [7:0]  store [logic [23:0]];
    logic [31:0] wlog [$];
    int          errors = 0;
    int          check_count = 0;
    wire         scl_w = mdl_scl & ~scl_oe;
    wire         sda_w = mdl_sda & ~sda_oe;

    always #5 pclk = ~pclk;

    i2csm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack));
    i2csm_master_mdl mdl (.scl(mdl_scl), .sda(mdl_sda), .sda_bus(sda_w));

    // unwritten places read as a fixed odd pattern, never a stale byte
    always @(posedge pclk) begin
        mem_ack <= mem_req & ~mem_ack;
        mem_rdata <= store.exists(mem_addr) ? store[mem_addr] : 8'hE7;
        if (mem_req & mem_ack & mem_we)
            wlog.push_back({mem_addr, mem_wdata});
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q,
                       output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            errors++;
            final_report();
        end
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr
    task automatic rc(input logic [11:0] a, input logic ee, input logic [7:0] exp);
        logic [7:0] q;
        logic e;
        apb(1'b0, a, 8'h00, q, e);
        chk({23'h0, e, q}, {23'h0, ee, exp});
    endtask : rc
    task automatic wb(input logic [7:0] d, input logic exp);
        logic a;
        mdl.wr_byte(d, a);
        chk({31'h0, a}, {31'h0, exp});
    endtask : wb
    task automatic rb(input logic last, input logic [7:0] exp);
        logic [7:0] d;
        mdl.rd_byte(last, d);
        chk({24'h0, d}, {24'h0, exp});
    endtask : rb

    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rc(12'h004, 1'b0, 8'h5C);
        rc(12'h00C, 1'b0, 8'h00);
        rc(12'h040, 1'b0, 8'h01);
        rc(12'h38C, 1'b0, 8'h00);
        rc(12'h008, 1'b1, 8'h00);
        rc(12'h006, 1'b1, 8'h00);
        wr(12'h380, 8'h7F);
        rc(12'h380, 1'b0, 8'h00);
        mdl.start();
        wb(8'hA4, 1'b0);
        mdl.stop();
        wr(12'h004, 8'hA4);
        for (int k = 0; k < 2; k++) begin
            wr(12'h00C, k[7:0]);
            wlog.delete();
            mdl.start();
            wb(8'hA4, 1'b1);
            wb(8'h04, 1'b1);
            wb(8'h00, 1'b1);
            wb(8'hCC, 1'b1);
            wb(8'h11, 1'b1);
            wb(8'h22, 1'b1);
            mdl.stop();
            chk(wlog[0], 32'h8400CC11);
            chk(wlog[1], {24'h8400CC + 24'(k), 8'h22});
        end
        store[24'h800010] = 8'h5A;
        store[24'h800011] = 8'h6B;
        mdl.start();
        wb(8'hA4, 1'b1);
        wb(8'h00, 1'b1);
        wb(8'h00, 1'b1);
        wb(8'h10, 1'b1);
        mdl.start();
        wb(8'hA5, 1'b1);
        rb(1'b0, 8'h5A);
        rb(1'b1, 8'h6B);
        mdl.stop();
        wr(12'h00C, 8'h02);
        mdl.start();
        wb(8'hA4, 1'b0);
        mdl.stop();
        wr(12'h384, 8'h00);
        wr(12'h388, 8'h01);
        wr(12'h38C, 8'h84);
        wr(12'h00C, 8'h04);
        wlog.delete();
        mdl.start();
        wb(8'hA4, 1'b1);
        wb(8'h33, 1'b1);
        wb(8'h44, 1'b1);
        mdl.stop();
        chk(wlog[0], 32'h84010033);
        chk(wlog[1], 32'h84010144);
        rc(12'h380, 1'b0, 8'h01);
        store[24'h840140] = 8'h9C;
        mdl.start();
        wb(8'hA5, 1'b1);
        rb(1'b1, 8'h9C);
        mdl.stop();
        rc(12'h380, 1'b0, 8'h40);
        wlog.delete();
        mdl.start();
        wb(8'hA4, 1'b1);
        wb(8'h55, 1'b1);
        rc(12'h380, 1'b0, 8'h40);
        mdl.stop();
        chk(wlog[0], 32'h84010055);
        rc(12'h380, 1'b0, 8'h00);
        final_report();
    end
    initial begin
        #400us;
        errors++;
        final_report();
    end
endmodule : i2csm_tb
